// *** core/ddrc_pkg.sv ***
// ddrc_pkg: shared constants and types for the ddr command decoder core.
// assumes: one clock domain (ref_clk), commands sampled on its rising edge.
package ddrc_pkg;
  localparam int unsigned ROW_W     = 13;       // row / address width
  localparam int unsigned COL_W     = 10;       // column width
  localparam int unsigned NUM_BANKS = 4;        // four banks
  // address bit positions
  localparam int unsigned AP_BIT    = 10;       // auto-precharge / precharge-all select
  // mode register field positions
  localparam int unsigned MR_BL_LSB = 0;        // burst length bits 0..2
  localparam int unsigned MR_BT_BIT = 3;        // burst_type_bit
  localparam int unsigned MR_CL_LSB = 4;        // read_latency bits 4..6
  localparam int unsigned MR_OP_LSB = 7;        // operating mode bits 7 and above
  localparam int unsigned LOOP_RESET_BIT = 8;   // loop_reset_bit, self clearing
  localparam int unsigned LOOP_DISABLE_BIT = 0; // extended: loop_disable_bit
  localparam int unsigned DRIVE_STRENGTH_BIT = 1; // extended: drive_strength_bit
  // reset values
  localparam logic [ROW_W-1:0] MODE_RESET = 13'h0032;  // bl 4, seq, latency 3
  localparam logic [ROW_W-1:0] EXT_RESET  = 13'h0000;
  // burst length codes
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  // read latency codes (half-cycle latency rounded up to whole cycles)
  localparam logic [2:0] CL_CODE_2  = 3'h2;
  localparam logic [2:0] CL_CODE_3  = 3'h3;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  // command encodings {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    DDRC_CMD_MODE_LOAD  = 3'h0,
    DDRC_CMD_REFRESH    = 3'h1,
    DDRC_CMD_PRECHARGE  = 3'h2,
    DDRC_CMD_ACTIVATE   = 3'h3,
    DDRC_CMD_WRITE      = 3'h4,
    DDRC_CMD_READ       = 3'h5,
    DDRC_CMD_BURST_TERM = 3'h6,
    DDRC_CMD_NOP        = 3'h7
  } ddrc_cmd_t;
  // command bundle as seen at the pins
  typedef struct packed {
    logic             cs_n;
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic             cke;
    logic [1:0]       bank;
    logic [ROW_W-1:0] addr;
  } ddrc_cmd_bus_t;
  // one burst beat handed to the data side
  typedef struct packed {
    logic             wr;
    logic [1:0]       bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic             last;
  } ddrc_beat_t;
endpackage

// *** core/ddrc_skid.sv ***
// ddrc_skid: two-entry buffer with valid/ready on both sides.
// assumes: same clock on both sides; ready_in depends only on occupancy.
`timescale 1ns/1ps
`default_nettype none
module ddrc_skid #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // only the two-entry layout is built; refuse anything else at elaboration
  if (DEPTH != 2) begin : g_bad_depth
    $error("ddrc_skid supports DEPTH of 2 only");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage
  logic             wp_ff, nxt_wp;    // write pointer
  logic             rp_ff, nxt_rp;    // read pointer
  logic [1:0]       cnt_ff, nxt_cnt;  // occupancy
  logic             push, pop;
  // pointer and count updates
  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wp  = push ? ~wp_ff : wp_ff;
    nxt_rp  = pop ? ~rp_ff : rp_ff;
    nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
  // storage has no reset; valid gates its use
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  assign in_ready  = (cnt_ff != 2'h2);  // full refuses, back-pressure to source
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
endmodule
`default_nettype wire

// *** core/ddrc_core.sv ***
// ddrc_core: command decode, bank state, mode registers and burst sequencing.
// assumes: pins arrive unsynchronised; the two-stage sync inside here samples them.
`timescale 1ns/1ps
`default_nettype none
module ddrc_core
  import ddrc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 200  // loop lock wait before a read
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire ddrc_cmd_bus_t    cmd_pins,      // asynchronous command pins
  output ddrc_beat_t            beat_data,     // burst beat for the array side
  output logic                  beat_valid,
  input  wire logic             beat_ready,
  output logic [ROW_W-1:0]      mode_reg,
  output logic [ROW_W-1:0]      ext_mode_reg,
  output logic [NUM_BANKS-1:0]  bank_open,
  output logic                  self_refresh,
  output logic                  dq_oe,         // data pins driven
  output logic                  refresh_pulse, // one pulse per refresh
  output logic                  read_ready     // loop lock wait over
);
  // the lock counter is sixteen bits wide; refuse waits it cannot hold
  if (LOCK_CYCLES == 32'h0 || LOCK_CYCLES > 32'h0000FFFF) begin : g_bad_lock
    $error("LOCK_CYCLES must lie between 1 and 65535");
  end
  typedef enum logic [1:0] {
    DDRC_IDLE  = 2'b00,
    DDRC_BURST = 2'b01,
    DDRC_HOLD  = 2'b11
  } ddrc_state_t;
  // two-flop synchroniser for the pins
  ddrc_cmd_bus_t   sync1_ff, sync2_ff;
  logic            cke_prev_ff;       // clock enable at previous edge
  logic            self_ref_ff;       // in self refresh, commands ignored
  logic            nxt_self_ref;
  logic            skid_ready;        // beat buffer has room
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                       cke: 1'b0, bank: 2'h0, addr: '0};
      sync2_ff    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                       cke: 1'b0, bank: 2'h0, addr: '0};
      cke_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= cmd_pins;
      sync2_ff    <= sync1_ff;
      cke_prev_ff <= sync2_ff.cke;
    end
  end
  // decoded command; deselect and nop both fall to nop
  ddrc_cmd_t cmd;
  logic      cmd_live;
  always_comb begin
    cmd      = ddrc_cmd_t'({sync2_ff.ras_n, sync2_ff.cas_n, sync2_ff.we_n});
    // a high chip select or a stopped clock enable registers nothing
    cmd_live = !sync2_ff.cs_n && cke_prev_ff && !self_ref_ff;
  end
  // state registers
  ddrc_state_t      st_ff, nxt_st;
  logic [ROW_W-1:0] mode_ff, nxt_mode;
  logic [ROW_W-1:0] ext_ff, nxt_ext;
  logic [NUM_BANKS-1:0] open_ff, nxt_open;
  logic [ROW_W-1:0] row_ff [NUM_BANKS];
  logic             dq_oe_ff, nxt_dq_oe;
  logic [15:0]      lock_ff, nxt_lock;
  logic             wr_ff, nxt_wr;
  logic             ap_ff, nxt_ap;
  logic [1:0]       bb_ff, nxt_bb;
  logic [COL_W-1:0] col_ff, nxt_col;
  logic [2:0]       idx_ff, nxt_idx;
  logic [3:0]       lat_ff, nxt_lat;
  logic             refresh_ff, nxt_refresh;
  // burst length and latency from the mode register
  logic [2:0] bl_mask;
  logic [3:0] lat_cyc;
  always_comb begin
    unique case (mode_ff[MR_BL_LSB +: 3])
      BL_CODE_2: bl_mask = 3'h1;
      BL_CODE_8: bl_mask = 3'h7;
      default:   bl_mask = 3'h3;  // reserved codes behave as length 4
    endcase
    unique case (mode_ff[MR_CL_LSB +: 3])
      CL_CODE_2: lat_cyc = 4'h2;
      CL_CODE_3, CL_CODE_25: lat_cyc = 4'h3;  // 2.5 rounds up on a single-edge core
      default:   lat_cyc = 4'h3;
    endcase
  end
  // column of the current beat: wraps within the aligned block
  logic [2:0] low_col;
  always_comb begin
    if (mode_ff[MR_BT_BIT]) begin
      low_col = (col_ff[2:0] ^ idx_ff) & bl_mask;   // interleaved
    end else begin
      low_col = (col_ff[2:0] + idx_ff) & bl_mask;   // sequential
    end
  end
  // main next-state process
  always_comb begin
    nxt_st       = st_ff;
    nxt_mode     = mode_ff;
    nxt_ext      = ext_ff;
    nxt_open     = open_ff;
    nxt_self_ref = self_ref_ff;
    nxt_dq_oe    = dq_oe_ff;
    nxt_lock     = (lock_ff != 16'h0 && sync2_ff.cke) ? lock_ff - 16'h1 : lock_ff;
    nxt_wr       = wr_ff;
    nxt_ap       = ap_ff;
    nxt_bb       = bb_ff;
    nxt_col      = col_ff;
    nxt_idx      = idx_ff;
    nxt_lat      = lat_ff;
    nxt_refresh  = 1'b0;
    // self refresh exits when clock enable returns
    if (self_ref_ff && sync2_ff.cke) begin
      nxt_self_ref = 1'b0;
      nxt_lock     = 16'(LOCK_CYCLES);  // loop re-enabled on exit
    end
    // burst sequencing, continues regardless of new nops
    if (st_ff == DDRC_BURST) begin
      if (lat_ff != 4'h0) begin
        nxt_lat = lat_ff - 4'h1;
      end else if (skid_ready) begin
        // advance only when the buffer takes the beat, so a stall repeats nothing
        nxt_idx = idx_ff + 3'h1;
        if ((idx_ff & bl_mask) == bl_mask) begin
          nxt_st = DDRC_IDLE;
          if (ap_ff) begin
            nxt_open[bb_ff] = 1'b0;  // auto-precharge after the burst
          end
        end
      end
    end
    if (cmd_live) begin
      unique case (cmd)
        DDRC_CMD_MODE_LOAD: begin
          // relies on controller only loading with banks idle
          if (sync2_ff.bank == 2'h0) begin
            nxt_mode = sync2_ff.addr;
            if (sync2_ff.addr[LOOP_RESET_BIT]) begin
              nxt_lock = 16'(LOCK_CYCLES);
              nxt_mode[LOOP_RESET_BIT] = 1'b0;  // self clearing
            end
          end else if (sync2_ff.bank == 2'h1) begin
            nxt_ext = sync2_ff.addr;
          end
        end
        DDRC_CMD_REFRESH: begin
          if (!sync2_ff.cke) begin
            nxt_self_ref = 1'b1;
          end else begin
            nxt_refresh = 1'b1;   // one refresh per command
          end
        end
        DDRC_CMD_PRECHARGE: begin
          if (sync2_ff.addr[AP_BIT]) begin
            nxt_open = '0;                      // all banks
          end else begin
            nxt_open[sync2_ff.bank] = 1'b0;
          end
        end
        DDRC_CMD_ACTIVATE: begin
          nxt_open[sync2_ff.bank] = 1'b1;
        end
        DDRC_CMD_READ, DDRC_CMD_WRITE: begin
          if (open_ff[sync2_ff.bank]) begin     // needs an open row
            nxt_st  = DDRC_BURST;
            nxt_wr  = (cmd == DDRC_CMD_WRITE);
            nxt_ap  = sync2_ff.addr[AP_BIT];
            nxt_bb  = sync2_ff.bank;
            nxt_col = sync2_ff.addr[COL_W-1:0];
            nxt_idx = 3'h0;
            nxt_lat = (cmd == DDRC_CMD_WRITE) ? 4'h0 : lat_cyc - 4'h1;
            if (cmd == DDRC_CMD_READ) begin
              nxt_dq_oe   = 1'b1;  // each read drives the data pins
            end
          end
        end
        DDRC_CMD_BURST_TERM: begin
          // only a plain read is cut; its row stays open
          if (st_ff == DDRC_BURST && !wr_ff && !ap_ff) begin
            nxt_st = DDRC_IDLE;
          end
        end
        DDRC_CMD_NOP: begin
        end
      endcase
    end
    if (nxt_st == DDRC_IDLE && !nxt_wr) begin
      nxt_dq_oe = 1'b0;  // release the data pins when idle after a read burst
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff       <= DDRC_IDLE;
      mode_ff     <= MODE_RESET;
      ext_ff      <= EXT_RESET;
      open_ff     <= '0;
      self_ref_ff <= 1'b0;
      dq_oe_ff    <= 1'b0;   // high impedance from power-up
      lock_ff     <= 16'h0;
      wr_ff       <= 1'b0;
      ap_ff       <= 1'b0;
      bb_ff       <= 2'h0;
      col_ff      <= '0;
      idx_ff      <= 3'h0;
      lat_ff      <= 4'h0;
      refresh_ff  <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      mode_ff     <= nxt_mode;
      ext_ff      <= nxt_ext;
      open_ff     <= nxt_open;
      self_ref_ff <= nxt_self_ref;
      dq_oe_ff    <= nxt_dq_oe;
      lock_ff     <= nxt_lock;
      wr_ff       <= nxt_wr;
      ap_ff       <= nxt_ap;
      bb_ff       <= nxt_bb;
      col_ff      <= nxt_col;
      idx_ff      <= nxt_idx;
      lat_ff      <= nxt_lat;
      refresh_ff  <= nxt_refresh;
    end
  end
  // open row per bank kept for the beat address
  always_ff @(posedge ref_clk) begin
    if (cmd_live && cmd == DDRC_CMD_ACTIVATE) begin
      row_ff[sync2_ff.bank] <= sync2_ff.addr;
    end
  end
  // beats go through a two-entry buffer so a stalled sink loses nothing
  ddrc_beat_t beat_in;
  logic       beat_in_valid;
  always_comb begin
    beat_in.wr    = wr_ff;
    beat_in.bank  = bb_ff;
    beat_in.row   = row_ff[bb_ff];
    beat_in.col   = {col_ff[COL_W-1:3], (col_ff[2:0] & ~bl_mask) | low_col};
    beat_in.last  = ((idx_ff & bl_mask) == bl_mask);
    beat_in_valid = (st_ff == DDRC_BURST) && (lat_ff == 4'h0);
  end
  ddrc_skid #(
    .WIDTH ($bits(ddrc_beat_t)),
    .DEPTH (2)
  ) u_skid (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (beat_in_valid && skid_ready),
    .in_ready  (skid_ready),
    .in_data   (beat_in),
    .out_valid (beat_valid),
    .out_ready (beat_ready),
    .out_data  (beat_data)
  );
  assign mode_reg      = mode_ff;
  assign ext_mode_reg  = ext_ff;
  assign bank_open     = open_ff;
  assign self_refresh  = self_ref_ff;
  assign dq_oe         = dq_oe_ff;
  assign refresh_pulse = refresh_ff;
  assign read_ready    = (lock_ff == 16'h0);
endmodule
`default_nettype wire

// *** sim/ddrc_core_asserts.sv ***
// ddrc_core_asserts: port-level checks on the ddr command core.
// assumes: pins change just after a rising edge; effects land within eight clocks.
`timescale 1ns/1ps
`default_nettype none
module ddrc_core_asserts
  import ddrc_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire ddrc_cmd_bus_t        cmd_pins,
  input wire ddrc_beat_t           beat_data,
  input wire logic                 beat_valid,
  input wire logic                 beat_ready,
  input wire logic [ROW_W-1:0]     mode_reg,
  input wire logic [ROW_W-1:0]     ext_mode_reg,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire logic                 self_refresh,
  input wire logic                 dq_oe,
  input wire logic                 refresh_pulse,
  input wire logic                 read_ready
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  logic [2:0]      cmd;       // strobes as one code
  logic [5:0]      hit;       // selected command on the pins now
  logic [5:0][7:0] hist_ff;   // recent commands, newest in bit 0
  logic [5:0][7:0] nxt_hist;
  // pins are async and synced inside, so causes are looked up over a window
  always_comb begin
    cmd    = {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
    hit[0] = !cmd_pins.cs_n && cmd == DDRC_CMD_MODE_LOAD && cmd_pins.bank == 2'h0;
    hit[1] = !cmd_pins.cs_n && cmd == DDRC_CMD_MODE_LOAD && cmd_pins.bank == 2'h1;
    hit[2] = !cmd_pins.cs_n && cmd == DDRC_CMD_ACTIVATE;
    hit[3] = !cmd_pins.cs_n && cmd == DDRC_CMD_PRECHARGE;
    hit[4] = !cmd_pins.cs_n && cmd == DDRC_CMD_READ;
    hit[5] = !cmd_pins.cs_n && cmd == DDRC_CMD_REFRESH;
    for (int k = 0; k < 6; k++) begin
      nxt_hist[k] = {hist_ff[k][6:0], hit[k]};
    end
  end
  // history registers only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_ff <= '0;
    end else begin
      hist_ff <= nxt_hist;
    end
  end
  beat_hold_a: assert property (beat_valid && !beat_ready
    |=> beat_valid && $stable(beat_data))
    else $error("beat dropped or changed while stalled");
  mode_cause_a: assert property ($changed(mode_reg[7:0]) |-> hist_ff[0] != 8'h00)
    else $error("mode register changed without bank 0 mode load");
  ext_cause_a: assert property ($changed(ext_mode_reg) |-> hist_ff[1] != 8'h00)
    else $error("extended register changed without bank 1 mode load");
  open_cause_a: assert property (|(bank_open & ~$past(bank_open)) |-> hist_ff[2] != 8'h00)
    else $error("bank opened without activate");
  close_all_a: assert property (hit[3] && cmd_pins.addr[AP_BIT] && cmd_pins.cke
    |-> ##[1:6] bank_open == 4'h0)
    else $error("precharge all left a bank open");
  refresh_one_a: assert property (refresh_pulse |-> hist_ff[5] != 8'h00 ##1 !refresh_pulse)
    else $error("refresh pulse without command or too long");
  self_entry_a: assert property (hit[5] && !cmd_pins.cke |-> ##[1:6] self_refresh)
    else $error("self refresh not entered");
  oe_cause_a: assert property ($rose(dq_oe) |-> hist_ff[4] != 8'h00)
    else $error("data pins driven without read");
  // self refresh exit re-enables the loop and restarts the wait as well
  lock_cause_a: assert property ($fell(read_ready) |-> hist_ff[0] != 8'h00 || $past(self_refresh))
    else $error("lock wait started without mode load");
  cover property (beat_valid && !beat_ready);
  cover property (self_refresh);
  cover property (refresh_pulse);
endmodule
bind ddrc_core ddrc_core_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .cmd_pins(cmd_pins), .beat_data(beat_data), .beat_valid(beat_valid),
  .beat_ready(beat_ready), .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
  .bank_open(bank_open), .self_refresh(self_refresh), .dq_oe(dq_oe),
  .refresh_pulse(refresh_pulse), .read_ready(read_ready));
`default_nettype wire

// *** sim/ddrc_ctl_model.sv ***
// ddrc_ctl_model: memory controller side, drives one command then a nop.
// assumes: caller keeps the init order and waits; pins move just after edges.
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctl_model
  import ddrc_pkg::*;
(
  input  wire logic    ref_clk,
  output var ddrc_cmd_bus_t cmd_pins
);
  // clock enable low through power-up
  initial begin
    cmd_pins = {1'b0, DDRC_CMD_NOP, 1'b0, 2'h0, 13'h0000};
  end
  // one command edge, then a nop with bank/address flipped so stale values never match
  task issue(input logic cs_n, input ddrc_cmd_t c, input logic [1:0] b,
             input logic [ROW_W-1:0] a, input logic ck);
    @(posedge ref_clk);
    cmd_pins <= {cs_n, c, ck, b, a};
    @(posedge ref_clk);
    cmd_pins <= {1'b0, DDRC_CMD_NOP, ck, ~b, ~a};
  endtask
endmodule
`default_nettype wire

// *** sim/tb_ddrc_core.sv ***
// tb_ddrc_core: command sequences against the core with a stalling beat sink.
// assumes: short loop-lock wait; model issues commands, tb consumes beats.
`timescale 1ns/1ps
`default_nettype none
module tb_ddrc_core;
  import ddrc_pkg::*;
  logic                 ref_clk, reset_n, beat_ready, beat_valid;
  logic                 self_refresh, dq_oe, refresh_pulse, read_ready, oe_seen;
  ddrc_cmd_bus_t        cmd_pins;
  ddrc_beat_t           beat_data;
  logic [ROW_W-1:0]     mode_reg, ext_mode_reg;
  logic [NUM_BANKS-1:0] bank_open;
  int                   bad_count, n_compared, n_ref;
  ddrc_beat_t           got[$];  // beats taken by the sink
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  ddrc_ctl_model ctl (.ref_clk(ref_clk), .cmd_pins(cmd_pins));
  ddrc_core #(.LOCK_CYCLES(4)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_pins(cmd_pins), .beat_data(beat_data), .beat_valid(beat_valid),
    .beat_ready(beat_ready), .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
    .bank_open(bank_open), .self_refresh(self_refresh), .dq_oe(dq_oe),
    .refresh_pulse(refresh_pulse), .read_ready(read_ready));
  // watch settled pulses between edges
  always @(negedge ref_clk) begin
    if (refresh_pulse === 1'b1) n_ref++;
    if (dq_oe === 1'b1) oe_seen = 1'b1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task cmd(input ddrc_cmd_t c, input logic [1:0] b, input logic [ROW_W-1:0] a);
    ctl.issue(1'b0, c, b, a, 1'b1);
  endtask
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // sink stalls every other cycle so the buffer fills
  task take(input int n);
    int w;
    got.delete();
    w = 0;
    while (got.size() < n && w < 200) begin
      @(negedge ref_clk);
      if (beat_valid === 1'b1 && beat_ready === 1'b1) got.push_back(beat_data);
      @(posedge ref_clk);
      beat_ready <= w[0];
      w++;
    end
    chk(got.size(), n);
  endtask
  // wrap inside the aligned block: add for sequential, xor for interleaved
  function automatic logic [COL_W-1:0] ecol(logic [COL_W-1:0] c, int bl, logic il, int i);
    logic [COL_W-1:0] m;
    m = COL_W'(bl - 1);
    return (c & ~m) | ((il ? (c ^ COL_W'(i)) : (c + COL_W'(i))) & m);
  endfunction
  task burst(input logic wr, input logic [1:0] b, input logic [ROW_W-1:0] row,
             input logic [ROW_W-1:0] a, input int bl, input logic il);
    cmd(wr ? DDRC_CMD_WRITE : DDRC_CMD_READ, b, a);
    take(bl);
    for (int i = 0; i < bl; i++) begin
      chk(got[i], {wr, b, row, ecol(a[COL_W-1:0], bl, il, i), i == bl - 1});
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    int         bl;
    logic       il;
    logic [2:0] blc;
    reset_n = 1'b0;
    beat_ready = 1'b1;
    oe_seen = 1'b0;
    bad_count = 0;
    n_compared = 0;
    n_ref = 0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(2);
    chk(mode_reg, MODE_RESET);
    chk({bank_open, self_refresh, dq_oe, beat_valid, read_ready}, 8'h01);
    $display("test reset done");
    ctl.issue(1'b0, DDRC_CMD_NOP, 2'h0, 13'h0000, 1'b1); // clock enable up
    cmd(DDRC_CMD_PRECHARGE, 2'h0, 13'h0400); // precharge all, then wait
    idle(2);
    cmd(DDRC_CMD_MODE_LOAD, 2'h1, 13'h0002);
    idle(4);
    chk(ext_mode_reg, 13'h0002);
    cmd(DDRC_CMD_MODE_LOAD, 2'h0, 13'h0122);
    idle(3);
    chk(read_ready, 1'b0);
    idle(8);
    chk(read_ready, 1'b1);
    chk(mode_reg, 13'h0022);
    cmd(DDRC_CMD_PRECHARGE, 2'h0, 13'h0400);
    idle(2);
    cmd(DDRC_CMD_REFRESH, 2'h0, 13'h0000);
    idle(3);
    cmd(DDRC_CMD_REFRESH, 2'h0, 13'h0000);
    idle(5);
    chk(n_ref, 2);
    cmd(DDRC_CMD_MODE_LOAD, 2'h0, 13'h0022); // loop reset bit low, same parameters
    cmd(DDRC_CMD_MODE_LOAD, 2'h2, 13'h0033);
    ctl.issue(1'b1, DDRC_CMD_MODE_LOAD, 2'h0, 13'h0031, 1'b1);
    idle(6);
    chk(mode_reg, 13'h0022);
    chk(ext_mode_reg, 13'h0002); // bank 2 load refused
    $display("test init done");
    for (int k = 0; k < 6; k++) begin
      il = k[0];
      blc = BL_CODE_2 + 3'(k / 2);
      bl = 2 << (k / 2);
      cmd(DDRC_CMD_PRECHARGE, 2'h0, 13'h0400);
      idle(2);
      cmd(DDRC_CMD_MODE_LOAD, 2'h0, 13'({3'h3, il, blc})); // banks idle first
      idle(3);
      cmd(DDRC_CMD_ACTIVATE, 2'h2, 13'h0ABC);
      idle(3);
      chk(bank_open, 4'h4);
      burst(1'b1, 2'h2, 13'h0ABC, 13'(10'h0F3 - k), bl, il);
      burst(1'b0, 2'h2, 13'h0ABC, 13'(10'h02D + k), bl, il);
    end
    chk(oe_seen, 1'b1);
    $display("test bursts done");
    burst(1'b0, 2'h2, 13'h0ABC, 13'h0402, 8, 1'b1);
    idle(6);
    chk(bank_open, 4'h0);
    cmd(DDRC_CMD_ACTIVATE, 2'h1, 13'h0011);
    cmd(DDRC_CMD_ACTIVATE, 2'h3, 13'h0033);
    idle(3);
    cmd(DDRC_CMD_PRECHARGE, 2'h1, 13'h0000);
    idle(4);
    chk(bank_open, 4'h8);
    $display("test precharge done");
    cmd(DDRC_CMD_READ, 2'h3, 13'h0000);
    cmd(DDRC_CMD_BURST_TERM, 2'h3, 13'h0000);
    // sink held off so any beat of an uncut burst would stay visible
    repeat (20) @(posedge ref_clk) beat_ready <= 1'b0;
    chk({bank_open[3], beat_valid}, 2'h2);
    $display("test terminate done");
    cmd(DDRC_CMD_PRECHARGE, 2'h0, 13'h0400);
    idle(2);
    ctl.issue(1'b0, DDRC_CMD_REFRESH, 2'h0, 13'h0000, 1'b0);
    idle(4);
    chk(self_refresh, 1'b1);
    $display("test self refresh done");
    conclude();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
